// File: core/port_clock_gate_defines.vh
// Purpose: Offsets, field positions, reset values for port clock gating
// Assumes: APB byte addresses, 32-bit data
// Notes:   Definitions only
`ifndef PORT_CLOCK_GATE_DEFINES_VH
`define PORT_CLOCK_GATE_DEFINES_VH

`define RUN_MODE_CLOCK_CONFIG_OFF         12'h060
`define RUN_PORT_CLOCK_ENABLES_OFF        12'h108
`define SLEEP_PORT_CLOCK_ENABLES_OFF      12'h118
`define DEEP_SLEEP_PORT_CLOCK_ENABLES_OFF 12'h128
`define POWER_STATE_OFF                   12'h200

`define PORT_COUNT                        5
`define PORT_A_BIT                        0
`define PORT_E_BIT                        4
`define AUTO_CLOCK_GATING_BIT             11
`define GATE_RESET                        5'h00
`define CONFIG_RESET                      1'b0

`define PSTATE_RUN                        2'h0
`define PSTATE_SLEEP                      2'h1
`define PSTATE_DEEP                       2'h2

`define PORT_WINDOW_SIZE                  32'h00001000

`endif

// File: core/port_enable_select.v
// Purpose: Picks the effective per-port clock enables for the power state
// Assumes: Power state and auto gating bit are registered upstream
// Notes:   Pure combinational mux
`timescale 1ns/10ps
`include "port_clock_gate_defines.vh"

module port_enable_select #(
    parameter N = `PORT_COUNT
) (
    // Enable sets
    input  wire [N-1:0] i_run_en,
    input  wire [N-1:0] i_sleep_en,
    input  wire [N-1:0] i_deep_en,
    // Mode
    input  wire         i_auto_gate,
    input  wire [1:0]   i_pstate,
    // Result
    output reg  [N-1:0] o_eff_en
);

    always @* begin
        // Without auto gating the sleep sets are ignored
        if (!i_auto_gate) begin
            o_eff_en = i_run_en;
        end else begin
            case (i_pstate)
                `PSTATE_SLEEP: o_eff_en = i_sleep_en;
                `PSTATE_DEEP:  o_eff_en = i_deep_en;
                default:       o_eff_en = i_run_en;
            endcase
        end
    end

endmodule

// File: core/deep_sleep_port_clock_gate.v
// Purpose: Deep-sleep, sleep and run clock gating for five I/O ports
// Assumes: APB slave on i_mclk; port accesses flagged by the bus fabric
// Notes:   Gate registers are five bits, upper bits read as zero
//          Read data is loaded in the setup cycle, no wait states
//          Enables reach the ports one edge after a write lands
//          Port selects 5 to 7 have no port and always fault
//          Clock gate cells themselves sit outside this block
//
// How it works
// - Each enable bit clocks exactly one port
// - Access to unclocked port gives bus fault
// - All gating bits zero after reset
// - Run, sleep and deep-sleep registers exist
// - Sleep sets apply only with auto gating
// - Bits 31 to 5 of the gate registers read zero
// - Bit 4 port E, bits 3..0 D..A
// - Deep-sleep register at offset 0x128
`timescale 1ns/10ps
`include "port_clock_gate_defines.vh"

module deep_sleep_port_clock_gate #(
    parameter N = `PORT_COUNT
) (
    // Clock and reset
    input  wire          i_mclk,
    input  wire          i_rst_b,
    // APB slave for the control registers
    input  wire          i_psel,
    input  wire          i_penable,
    input  wire          i_pwrite,
    input  wire [11:0]   i_paddr,
    input  wire [31:0]   i_pwdata,
    output wire          o_pready,
    output reg  [31:0]   o_prdata,
    output wire          o_pslverr,
    // Power state from the power manager
    input  wire [1:0]    i_pstate,
    // Port access check from the fabric
    input  wire          i_port_access,
    input  wire [2:0]    i_port_sel,
    output wire          o_port_fault,
    // Per-port clock enables
    output reg  [N-1:0]  o_port_clk_en
);

    ////////////////////////////////////////////////////////////////////////////
    // One select bit per mapped word
    localparam SEL_CONFIG = 0;
    localparam SEL_RUN    = 1;
    localparam SEL_SLEEP  = 2;
    localparam SEL_DEEP   = 3;
    localparam SEL_STATUS = 4;
    localparam SEL_COUNT  = 5;
    // A three-bit port select reaches eight slots, absent ones act as gated
    localparam SLOTS      = 8;

    reg  [N-1:0]         run_port_clock_enables_q;
    reg  [N-1:0]         sleep_port_clock_enables_q;
    reg  [N-1:0]         deep_sleep_port_clock_enables_q;
    reg                  auto_clock_gating_q;
    reg  [31:0]          rdata_d;
    wire [N-1:0]         eff_en;
    wire [SEL_COUNT-1:0] addr_sel;
    wire                 setup_ph;
    wire                 access_ph;
    wire                 hit;
    wire                 wr_en;
    wire                 rd_setup;
    wire                 wr_config;
    wire                 wr_run;
    wire                 wr_sleep;
    wire                 wr_deep;
    wire [SLOTS-1:0]     slot_fault;

    ////////////////////////////////////////////////////////////////////////////
    function [SEL_COUNT-1:0] reg_sel;
        input [11:0] addr;
        begin
            reg_sel = {SEL_COUNT{1'b0}};
            case (addr)
                `RUN_MODE_CLOCK_CONFIG_OFF:         reg_sel[SEL_CONFIG] = 1'b1;
                `RUN_PORT_CLOCK_ENABLES_OFF:        reg_sel[SEL_RUN]    = 1'b1;
                `SLEEP_PORT_CLOCK_ENABLES_OFF:      reg_sel[SEL_SLEEP]  = 1'b1;
                `DEEP_SLEEP_PORT_CLOCK_ENABLES_OFF: reg_sel[SEL_DEEP]   = 1'b1;
                `POWER_STATE_OFF:                   reg_sel[SEL_STATUS] = 1'b1;
                default:                            reg_sel = {SEL_COUNT{1'b0}};
            endcase
        end
    endfunction

    // Only the enable field of a write lands, reserved bits are dropped
    function [N-1:0] gate_field;
        input [31:0] wdata;
        begin
            gate_field = wdata[N-1:0];
        end
    endfunction

    assign addr_sel  = reg_sel(i_paddr);
    assign hit       = |addr_sel;
    assign setup_ph  = i_psel & ~i_penable;
    assign access_ph = i_psel & i_penable;
    assign wr_en     = access_ph & i_pwrite;
    assign rd_setup  = setup_ph & ~i_pwrite;

    // Write strobes, one per writable register, none for the read-only status word
    assign wr_config = wr_en & addr_sel[SEL_CONFIG];
    assign wr_run    = wr_en & addr_sel[SEL_RUN];
    assign wr_sleep  = wr_en & addr_sel[SEL_SLEEP];
    assign wr_deep   = wr_en & addr_sel[SEL_DEEP];

    // Zero-wait slave keeps the fabric simple
    assign o_pready  = 1'b1;
    assign o_pslverr = access_ph & ~hit;

    ////////////////////////////////////////////////////////////////////////////
    // Each register has its own process so a write reaches only its word
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            auto_clock_gating_q <= `CONFIG_RESET;
        end else if (wr_config) begin
            auto_clock_gating_q <= i_pwdata[`AUTO_CLOCK_GATING_BIT];
        end
    end

    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            run_port_clock_enables_q <= `GATE_RESET;
        end else if (wr_run) begin
            run_port_clock_enables_q <= gate_field(i_pwdata);
        end
    end

    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sleep_port_clock_enables_q <= `GATE_RESET;
        end else if (wr_sleep) begin
            sleep_port_clock_enables_q <= gate_field(i_pwdata);
        end
    end

    // Upper write data dropped so reserved bits stay zero
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            deep_sleep_port_clock_enables_q <= `GATE_RESET;
        end else if (wr_deep) begin
            deep_sleep_port_clock_enables_q <= gate_field(i_pwdata);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reserved and unmapped bits default to zero
    always @* begin
        rdata_d = 32'h00000000;
        if (addr_sel[SEL_CONFIG]) begin
            rdata_d[`AUTO_CLOCK_GATING_BIT] = auto_clock_gating_q;
        end
        if (addr_sel[SEL_RUN]) begin
            rdata_d[N-1:0] = run_port_clock_enables_q;
        end
        if (addr_sel[SEL_SLEEP]) begin
            rdata_d[N-1:0] = sleep_port_clock_enables_q;
        end
        if (addr_sel[SEL_DEEP]) begin
            rdata_d[N-1:0] = deep_sleep_port_clock_enables_q;
        end
        // Status: power state in 1:0, selected enables from bit 5 up
        if (addr_sel[SEL_STATUS]) begin
            rdata_d[1:0]   = i_pstate;
            rdata_d[N+4:5] = eff_en;
        end
    end

    // Loaded in the setup cycle so the word stands through the access phase
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_prdata <= 32'h00000000;
        end else if (rd_setup) begin
            o_prdata <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    port_enable_select #(
        .N (N)
    ) u_sel (
        .i_run_en    (run_port_clock_enables_q),
        .i_sleep_en  (sleep_port_clock_enables_q),
        .i_deep_en   (deep_sleep_port_clock_enables_q),
        .i_auto_gate (auto_clock_gating_q),
        .i_pstate    (i_pstate),
        .o_eff_en    (eff_en)
    );

    // Registered so the enables are glitch free toward clock gate cells
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_port_clk_en <= `GATE_RESET;
        end else begin
            o_port_clk_en <= eff_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault uses the applied enable, not a pending one
    genvar p;

    generate
        for (p = 0; p < SLOTS; p = p + 1) begin : g_slot
            if (p < N) begin : g_port
                assign slot_fault[p] = ~o_port_clk_en[p];
            end else begin : g_absent
                // No port behind this select, so every access faults
                assign slot_fault[p] = 1'b1;
            end
        end
    endgenerate

    assign o_port_fault = i_port_access & slot_fault[i_port_sel];

endmodule

// File: tb/port_gate_chk_properties.sv
// Purpose: Port clock gate checker
// Assumes: Top module ports only
// Notes:   Auto gating bit is tracked from bus writes
`timescale 1ns/10ps
module port_gate_chk #(
    parameter N = 5
) (
    input wire logic         i_mclk, i_rst_b, i_psel, i_penable, i_pwrite,
    input wire logic [11:0]  i_paddr,
    input wire logic [31:0]  i_pwdata, o_prdata,
    input wire logic         o_pready, o_pslverr, i_port_access, o_port_fault,
    input wire logic [1:0]   i_pstate,
    input wire logic [2:0]   i_port_sel,
    input wire logic [N-1:0] o_port_clk_en
);
    logic auto_q;
    wire  acc = i_psel && i_penable;
    wire  wr  = acc && i_pwrite;
    wire  map = i_paddr inside {12'h060, 12'h108, 12'h118, 12'h128, 12'h200};
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    ////////////////////////////////////////
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b)
            auto_q <= 1'b0;
        else if (wr && i_paddr == 12'h060)
            auto_q <= i_pwdata[11];
    end
    AST_BADSEL: assert property (i_port_access && i_port_sel > 3'h4 |-> o_port_fault)
        else $error("no fault on absent port");
    AST_GATED: assert property (i_port_access && i_port_sel < 3'h5 |->
        o_port_fault == !o_port_clk_en[i_port_sel]) else $error("fault not per enable");
    AST_IDLE: assert property (!i_port_access |-> !o_port_fault)
        else $error("fault without access");
    AST_RST: assert property ($rose(i_rst_b) |-> o_port_clk_en == '0)
        else $error("enables not clear after reset");
    AST_ERR: assert property (acc |-> o_pslverr == !map)
        else $error("slave error wrong");
    AST_DEEP: assert property (wr && i_paddr == 12'h128 && auto_q && i_pstate == 2'h2
        ##1 i_pstate == 2'h2 |=> o_port_clk_en == $past(i_pwdata[4:0], 2))
        else $error("deep set not applied");
    AST_RO: assert property (acc && !i_pwrite && i_paddr == 12'h128 |-> o_prdata[31:5] == '0)
        else $error("upper bits not zero");
    AST_AUTOOFF: assert property (!auto_q && !wr ##1 !wr ##1 1'b1 |=> $stable(o_port_clk_en))
        else $error("enables moved with auto gating off");
    cover property (acc && o_pslverr);
    cover property (i_port_access && o_port_fault);
    cover property (o_port_clk_en == 5'h1f);
endmodule
bind deep_sleep_port_clock_gate port_gate_chk #(.N(N)) u_chk (.i_mclk, .i_rst_b, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
    .i_port_access, .o_port_fault, .i_pstate, .i_port_sel, .o_port_clk_en);

// File: tb/deep_sleep_port_clock_gate_tb_top.sv
// Purpose: Bench for the port clock gate
// Assumes: Read data is taken at the edge that completes the access
// Notes:   Enables lag a write by one more edge
`timescale 1ns/10ps
module deep_sleep_port_clock_gate_tb_top;
    logic        i_mclk = 0, i_rst_b = 0, psel = 0, pen = 0, pwr = 0, acc = 0;
    logic [11:0] adr = 12'h000;
    logic [31:0] wd = 32'h0, prd, r;
    logic [1:0]  pst = 2'h0;
    logic [2:0]  sel = 3'h0;
    logic [4:0]  en;
    logic        rdy, serr, flt, e;
    int          err_count = 0, n_compared = 0, cyc = 0;
    deep_sleep_port_clock_gate dut (.i_mclk, .i_rst_b, .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(adr), .i_pwdata(wd), .o_pready(rdy), .o_prdata(prd),
        .o_pslverr(serr), .i_pstate(pst), .i_port_access(acc), .i_port_sel(sel),
        .o_port_fault(flt), .o_port_clk_en(en));
    initial forever #5 i_mclk = ~i_mclk;
    always @(posedge i_mclk) if (++cyc == 2000) begin
        err_count++;
        end_of_test();
    end
    ////////////////////////////////////////
    task automatic end_of_test();
        $display("Mismatches %0d, compared %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (g !== x) begin
            err_count++;
            $display("[ERR] %0t got %h want %h", $time, g, x);
        end
    endtask
    // Holds the request until ready is seen, takes data and error at that edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        psel <= 1'h1;
        pwr <= w;
        adr <= a;
        wd <= d;
        @(posedge i_mclk);
        pen <= 1'h1;
        do @(posedge i_mclk); while (rdy !== 1'h1);
        e = serr;
        r = prd;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask
    task automatic port(input int s, input logic x);
        acc <= 1'h1;
        sel <= s[2:0];
        @(posedge i_mclk);
        chk(flt, x);
        acc <= 1'h0;
        @(posedge i_mclk);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (10) @(posedge i_mclk);
        i_rst_b <= 1'h1;
        apb(0, 12'h128, 32'h0);
        chk(r, 32'h0);
        for (int i = 0; i < 8; i++) port(i, 1'h1);
        apb(1, 12'h060, 32'h800);
        pst <= 2'h2;
        apb(1, 12'h128, 32'hffffffff);
        apb(0, 12'h128, 32'h0);
        chk(r, 32'h1f);
        chk(en, 32'h1f);
        for (int i = 0; i < 5; i++) begin
            apb(1, 12'h128, 32'h1 << i);
            repeat (2) @(posedge i_mclk);
            chk(en, 32'h1 << i);
            port(i, 1'h0);
            port((i + 1) % 5, 1'h1);
        end
        apb(1, 12'h108, 32'h3);
        apb(1, 12'h118, 32'hc);
        apb(0, 12'h108, 32'h0);
        chk(r, 32'h3);
        pst <= 2'h0;
        repeat (2) @(posedge i_mclk);
        chk(en, 32'h3);
        pst <= 2'h1;
        repeat (2) @(posedge i_mclk);
        chk(en, 32'hc);
        apb(1, 12'h060, 32'h0);
        pst <= 2'h2;
        repeat (3) @(posedge i_mclk);
        chk(en, 32'h3);
        apb(0, 12'h200, 32'h0);
        chk(r, 32'h62);
        apb(0, 12'h124, 32'h0);
        chk(e, 32'h1);
        chk(r, 32'h0);
        end_of_test();
    end
endmodule
